// ---- core/ctl_pkg.sv ----
// package: constants, tag layout and carrier types of the cache tag lookup block
`default_nettype none
package ctl_pkg;

	// ------------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------------
	localparam int CTL_WAYS = 4;
	localparam int CTL_ENTRIES = 512;
	localparam int CTL_IDX_W = 9;
	localparam int CTL_TAG_W = 21;
	localparam int CTL_WORD_W = 32;
	localparam int CTL_LANES = 4;
	localparam int CTL_ENTRY_BYTES = 8;
	localparam int CTL_SET_BYTES = 4096;
	localparam int CTL_RAM_AW = 14;

	// ------------------------------------------------------------------
	// tag word field positions
	// ------------------------------------------------------------------
	localparam int CTL_TAG_LSB = 11;
	localparam int CTL_INVAL_BIT = 9;
	localparam int CTL_LOCK_BIT = 8;
	localparam int CTL_VALID_LSB = 4;

	// ------------------------------------------------------------------
	// direct ram address fields (byte address inside the 16 KB block)
	// ------------------------------------------------------------------
	localparam int CTL_RAM_SET_LSB = 12;
	localparam int CTL_RAM_IDX_LSB = 3;
	localparam int CTL_RAM_SEL_BIT = 2;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [20:0] tag_ref;
		logic unused;
		logic inval;
		logic lock;
		logic byte3_valid_flag;
		logic byte2_valid_flag;
		logic byte1_valid_flag;
		logic byte0_valid_flag;
		logic [3:0] rsvd;
	} ctl_tag_t;

	localparam ctl_tag_t CTL_TAG_RESET = '0;

	// core lookup: word address is A31..A2, lanes are by address offset
	typedef struct packed {
		logic valid;
		logic write;
		logic [29:0] waddr;
		logic [3:0] lanes;
		logic [31:0] wdata;
	} ctl_req_t;

	// line fill returned from external memory
	typedef struct packed {
		logic valid;
		logic [29:0] waddr;
		logic [3:0] lanes;
		logic [31:0] data;
	} ctl_fill_t;

	// direct word access to the tag and data storage
	typedef struct packed {
		logic valid;
		logic write;
		logic [13:0] addr;
		logic [31:0] wdata;
	} ctl_ram_req_t;

	// byte valid flags of a tag as a vector, flag k at bit k
	function automatic logic [3:0] ctl_flags(input ctl_tag_t t);
		ctl_flags = {t.byte3_valid_flag, t.byte2_valid_flag, t.byte1_valid_flag, t.byte0_valid_flag};
	endfunction

	// address-offset lanes to byte flags and back: identity little endian, mirrored big endian
	function automatic logic [3:0] ctl_lane_map(input logic [3:0] v, input logic big_endian);
		ctl_lane_map = big_endian ? {v[0], v[1], v[2], v[3]} : v;
	endfunction

endpackage : ctl_pkg
`default_nettype wire

// ---- core/ctl_way_cmp.sv ----
// module: tag compare of one way at the looked-up index
`default_nettype none
module ctl_way_cmp (
	// stored entry
	input wire ctl_pkg::ctl_tag_t tag,
	input wire logic way_en,
	// lookup
	input wire logic [20:0] addr_tag,
	input wire logic [3:0] need_flags,
	// result
	output logic line_valid,
	output logic match,
	output logic full
);
	import ctl_pkg::*;

	wire logic [3:0] flags = ctl_flags(tag);

	// a line with no byte flag set is clear and its tag means nothing
	assign line_valid = |flags;
	assign match = way_en && line_valid && !tag.inval && (tag.tag_ref == addr_tag);
	assign full = match && ((flags & need_flags) == need_flags);

endmodule // ctl_way_cmp
`default_nettype wire

// ---- core/ctl_cache_tag.sv ----
// module: four-way cache tag and data storage with lookup, fill and direct ram access
`default_nettype none
module ctl_cache_tag (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// configuration
	input wire logic big_endian,
	input wire logic [3:0] set_cache_en,
	// core lookup
	input wire ctl_pkg::ctl_req_t lk_req,
	output logic lk_hit,
	output logic lk_miss,
	output logic [31:0] lk_rdata,
	// line fill from external memory
	input wire ctl_pkg::ctl_fill_t fill,
	output logic fill_done,
	output logic fill_dropped,
	// direct ram access
	input wire ctl_pkg::ctl_ram_req_t ram_req,
	output logic ram_ack,
	output logic [31:0] ram_rdata
);
	import ctl_pkg::*;

	// ------------------------------------------------------------------
	// storage
	// ------------------------------------------------------------------
	ctl_tag_t tag_mem [CTL_WAYS][CTL_ENTRIES];
	logic [31:0] data_mem [CTL_WAYS][CTL_ENTRIES];
	logic [1:0] rr_r;
	logic lk_hit_r;
	logic lk_miss_r;
	logic [31:0] lk_rdata_r;
	logic fill_done_r;
	logic fill_dropped_r;
	logic ram_ack_r;
	logic [31:0] ram_rdata_r;

	// ------------------------------------------------------------------
	// lookup decode
	// ------------------------------------------------------------------
	wire logic [8:0] lk_idx = lk_req.waddr[8:0];
	wire logic [20:0] lk_tag = lk_req.waddr[29:9];
	wire logic [3:0] lk_need = ctl_lane_map(lk_req.lanes, big_endian);
	logic [3:0] lk_match;
	logic [3:0] lk_full;
	logic [3:0] lk_lvalid;

	genvar g;
	generate
		for (g = 0; g < CTL_WAYS; g++) begin : g_lk
			ctl_way_cmp u_cmp (
				.tag(tag_mem[g][lk_idx]),
				.way_en(set_cache_en[g]),
				.addr_tag(lk_tag),
				.need_flags(lk_need),
				.line_valid(lk_lvalid[g]),
				.match(lk_match[g]),
				.full(lk_full[g])
			);
		end
	endgenerate

	// reads need every requested byte valid, writes need the line present
	wire logic [3:0] lk_sel = lk_req.write ? lk_match : lk_full;
	wire logic lk_any = |lk_sel;
	logic [1:0] lk_way;
	always_comb begin
		lk_way = 2'h0;
		for (int w = CTL_WAYS - 1; w >= 0; w--) begin
			if (lk_sel[w]) begin
				lk_way = 2'(w);
			end
		end
	end
	wire logic lk_wr_hit = lk_req.valid && lk_req.write && lk_any;

	// ------------------------------------------------------------------
	// fill decode and victim choice
	// ------------------------------------------------------------------
	wire logic [8:0] fl_idx = fill.waddr[8:0];
	wire logic [20:0] fl_tag = fill.waddr[29:9];
	wire logic [3:0] fl_flags = ctl_lane_map(fill.lanes, big_endian);
	logic [3:0] fl_match;
	logic [3:0] fl_cand;

	generate
		for (g = 0; g < CTL_WAYS; g++) begin : g_fl
			ctl_way_cmp u_cmp (
				.tag(tag_mem[g][fl_idx]),
				.way_en(set_cache_en[g]),
				.addr_tag(fl_tag),
				.need_flags(4'h0),
				.line_valid(),
				.match(fl_match[g]),
				.full()
			);
			// only enabled, unlocked, allocatable lines may be replaced
			assign fl_cand[g] = set_cache_en[g] && !tag_mem[g][fl_idx].lock
				&& !tag_mem[g][fl_idx].inval;
		end
	endgenerate

	wire logic fl_merge = |fl_match;
	wire logic fl_ok = fl_merge || (|fl_cand);
	logic [1:0] fl_way;
	always_comb begin
		fl_way = 2'h0;
		if (fl_merge) begin
			for (int w = CTL_WAYS - 1; w >= 0; w--) begin
				if (fl_match[w]) begin
					fl_way = 2'(w);
				end
			end
		end else begin
			// round robin starting at rr_r
			for (int k = CTL_WAYS - 1; k >= 0; k--) begin
				if (fl_cand[2'(rr_r + 2'(k))]) begin
					fl_way = 2'(rr_r + 2'(k));
				end
			end
		end
	end
	wire logic fl_go = fill.valid && fl_ok;
	wire ctl_tag_t fl_old = tag_mem[fl_way][fl_idx];
	wire logic [3:0] fl_new_flags = fl_merge ? (ctl_flags(fl_old) | fl_flags) : fl_flags;
	logic [31:0] fl_new_data;
	logic [31:0] lk_new_data;
	always_comb begin
		fl_new_data = data_mem[fl_way][fl_idx];
		lk_new_data = data_mem[lk_way][lk_idx];
		for (int b = 0; b < CTL_LANES; b++) begin
			if (fill.lanes[b]) begin
				fl_new_data[8*b +: 8] = fill.data[8*b +: 8];
			end
			if (lk_req.lanes[b]) begin
				lk_new_data[8*b +: 8] = lk_req.wdata[8*b +: 8];
			end
		end
	end
	ctl_tag_t fl_new_tag;
	always_comb begin
		fl_new_tag = CTL_TAG_RESET;
		fl_new_tag.tag_ref = fl_tag;
		fl_new_tag.lock = fl_merge ? fl_old.lock : 1'b0;
		{fl_new_tag.byte3_valid_flag, fl_new_tag.byte2_valid_flag,
			fl_new_tag.byte1_valid_flag, fl_new_tag.byte0_valid_flag} = fl_new_flags;
	end
	ctl_tag_t lk_new_tag;
	always_comb begin
		lk_new_tag = tag_mem[lk_way][lk_idx];
		{lk_new_tag.byte3_valid_flag, lk_new_tag.byte2_valid_flag,
			lk_new_tag.byte1_valid_flag, lk_new_tag.byte0_valid_flag} = ctl_flags(lk_new_tag) | lk_need;
	end

	// ------------------------------------------------------------------
	// direct ram decode
	// ------------------------------------------------------------------
	wire logic [1:0] rm_way = ram_req.addr[13:CTL_RAM_SET_LSB];
	wire logic [8:0] rm_idx = ram_req.addr[11:CTL_RAM_IDX_LSB];
	wire logic rm_is_data = ram_req.addr[CTL_RAM_SEL_BIT];
	wire logic rm_wr = ram_req.valid && ram_req.write;

	// ------------------------------------------------------------------
	// storage update: write hit, then fill, then direct ram write wins
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			for (int w = 0; w < CTL_WAYS; w++) begin
				for (int i = 0; i < CTL_ENTRIES; i++) begin
					tag_mem[w][i] <= CTL_TAG_RESET;
				end
			end
		end else begin
			// write-through: cached copy tracks what goes to memory
			if (lk_wr_hit) begin
				tag_mem[lk_way][lk_idx] <= lk_new_tag;
			end
			if (fl_go) begin
				tag_mem[fl_way][fl_idx] <= fl_new_tag;
			end
			if (rm_wr && !rm_is_data) begin
				tag_mem[rm_way][rm_idx] <= ram_req.wdata;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (lk_wr_hit) begin
			data_mem[lk_way][lk_idx] <= lk_new_data;
		end
		if (fl_go) begin
			data_mem[fl_way][fl_idx] <= fl_new_data;
		end
		if (rm_wr && rm_is_data) begin
			data_mem[rm_way][rm_idx] <= ram_req.wdata;
		end
	end

	// ------------------------------------------------------------------
	// answers
	// ------------------------------------------------------------------
	wire logic [31:0] rm_rd = rm_is_data ? data_mem[rm_way][rm_idx] : 32'(tag_mem[rm_way][rm_idx]);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			lk_hit_r <= 1'b0;
			lk_miss_r <= 1'b0;
			lk_rdata_r <= 32'h0;
			fill_done_r <= 1'b0;
			fill_dropped_r <= 1'b0;
			ram_ack_r <= 1'b0;
			ram_rdata_r <= 32'h0;
			rr_r <= 2'h0;
		end else begin
			lk_hit_r <= lk_req.valid && lk_any;
			lk_miss_r <= lk_req.valid && !lk_any;
			if (lk_req.valid && lk_any && !lk_req.write) begin
				lk_rdata_r <= data_mem[lk_way][lk_idx];
			end
			fill_done_r <= fl_go;
			fill_dropped_r <= fill.valid && !fl_ok;
			if (fl_go && !fl_merge) begin
				rr_r <= fl_way + 2'h1;
			end
			ram_ack_r <= ram_req.valid;
			if (ram_req.valid && !ram_req.write) begin
				ram_rdata_r <= rm_rd;
			end
		end
	end

	assign lk_hit = lk_hit_r;
	assign lk_miss = lk_miss_r;
	assign lk_rdata = lk_rdata_r;
	assign fill_done = fill_done_r;
	assign fill_dropped = fill_dropped_r;
	assign ram_ack = ram_ack_r;
	assign ram_rdata = ram_rdata_r;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	wire logic fl_vic_lock = tag_mem[fl_way][fl_idx].lock;
	wire logic fl_vic_inval = tag_mem[fl_way][fl_idx].inval;
	wire logic fl_vic_clash = rm_wr && !rm_is_data && (rm_way == fl_way) && (rm_idx == fl_idx);

	a_lookup_answer: assert property (lk_req.valid |=> (lk_hit != lk_miss))
		else $error("lookup not answered by exactly one of hit or miss");
	a_idle_silent: assert property (!lk_req.valid |=> !lk_hit && !lk_miss)
		else $error("lookup answer without a request");
	a_clear_no_hit: assert property (lk_req.valid && !(|(lk_lvalid & set_cache_en)) |=> lk_miss)
		else $error("clear line produced a hit");
	a_hit_data: assert property (lk_req.valid && !lk_req.write && lk_any && !rm_wr && !fl_go
		|=> lk_rdata == $past(data_mem[lk_way][lk_idx]))
		else $error("hit data not taken from the selected line");
	a_lock_kept: assert property (fl_go && !fl_merge |-> !fl_vic_lock)
		else $error("locked line chosen for replacement");
	a_inval_skip: assert property (fl_go |-> !fl_vic_inval)
		else $error("invalidated line allocated");
	a_victim_enabled: assert property (fl_go |-> set_cache_en[fl_way])
		else $error("fill placed in a set used as plain ram");
	a_fill_tag: assert property (fl_go && !fl_vic_clash
		|=> tag_mem[$past(fl_way)][$past(fl_idx)].tag_ref == $past(fl_tag))
		else $error("fill did not store the address tag");
	a_fill_flags: assert property (fl_go && !fl_vic_clash
		|=> (ctl_flags(tag_mem[$past(fl_way)][$past(fl_idx)]) & $past(fl_flags)) == $past(fl_flags))
		else $error("filled bytes not flagged valid");
	a_drop_reason: assert property (fill.valid && (|(set_cache_en & ~fl_match)) == 1'b0 && !fl_merge
		|=> fill_dropped)
		else $error("fill with no enabled set not dropped");
	a_ram_answer: assert property (ram_req.valid && !ram_req.write |=> ram_ack && ram_rdata == $past(rm_rd))
		else $error("direct read answer wrong");

	c_read_hit: cover property (lk_req.valid && !lk_req.write ##1 lk_hit);
	c_read_miss: cover property (lk_req.valid && !lk_req.write ##1 lk_miss);
	c_fill_merge: cover property (fill.valid && fl_merge);
	c_fill_drop: cover property (fill_dropped);

endmodule // ctl_cache_tag
`default_nettype wire

// ---- tb/ctl_core_model.sv ----
// partner model: processor core and memory fill path on the lookup side
`default_nettype none
module ctl_core_model (
	// clock
	input wire logic sys_clk,
	// lookup side
	output var ctl_pkg::ctl_req_t lk_req,
	input wire logic lk_hit,
	input wire logic lk_miss,
	input wire logic [31:0] lk_rdata,
	// fill side
	output var ctl_pkg::ctl_fill_t fill,
	input wire logic fill_done,
	input wire logic fill_dropped
);
	timeunit 1ns;
	timeprecision 1ps;
	import ctl_pkg::*;

	initial begin
		lk_req = '0;
		fill = '0;
	end

	// idle lines show the inverse so a stale request never looks repeated
	task automatic look(input ctl_req_t r, output logic h, output logic m, output logic [31:0] d);
		ctl_req_t idle;
		idle = ~r;
		idle.valid = 1'b0;
		@(posedge sys_clk);
		lk_req <= r;
		@(posedge sys_clk);
		lk_req <= idle;
		@(negedge sys_clk);
		h = lk_hit;
		m = lk_miss;
		d = lk_rdata;
	endtask

	task automatic put_fill(input ctl_fill_t f, output logic dn, output logic dr);
		ctl_fill_t idle;
		idle = ~f;
		idle.valid = 1'b0;
		@(posedge sys_clk);
		fill <= f;
		@(posedge sys_clk);
		fill <= idle;
		@(negedge sys_clk);
		dn = fill_done;
		dr = fill_dropped;
	endtask
endmodule // ctl_core_model
`default_nettype wire

// ---- tb/cache_tag_lookup_test.sv ----
// testbench: direct ram, fill and lookup sequences with expected values
`default_nettype none
module cache_tag_lookup_test;
	timeunit 1ns;
	timeprecision 1ps;
	import ctl_pkg::*;

	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	logic sys_clk;
	logic resetn;
	logic big_endian;
	logic [3:0] set_cache_en;
	ctl_req_t lk_req;
	ctl_fill_t fill;
	ctl_ram_req_t ram_req;
	logic lk_hit;
	logic lk_miss;
	logic [31:0] lk_rdata;
	logic fill_done;
	logic fill_dropped;
	logic ram_ack;
	logic [31:0] ram_rdata;
	logic [31:0] rd;
	logic [31:0] lt[4];
	int fail_count = 0;
	int checks = 0;
	int cycles = 0;

	ctl_cache_tag u_ctl_cache_tag (.sys_clk(sys_clk), .resetn(resetn), .big_endian(big_endian),
		.set_cache_en(set_cache_en), .lk_req(lk_req), .lk_hit(lk_hit), .lk_miss(lk_miss),
		.lk_rdata(lk_rdata), .fill(fill), .fill_done(fill_done), .fill_dropped(fill_dropped),
		.ram_req(ram_req), .ram_ack(ram_ack), .ram_rdata(ram_rdata));

	ctl_core_model u_ctl_core_model (.sys_clk(sys_clk), .lk_req(lk_req), .lk_hit(lk_hit),
		.lk_miss(lk_miss), .lk_rdata(lk_rdata), .fill(fill), .fill_done(fill_done),
		.fill_dropped(fill_dropped));

	initial sys_clk = 1'b0;
	always #20 sys_clk = ~sys_clk;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [13:0] ra(input logic [1:0] s, input logic [8:0] i, input logic sel);
		ra = {s, i, sel, 2'b00};
	endfunction

	function automatic logic [31:0] tw(input logic [20:0] t, input logic inv, input logic lk, input logic [3:0] f);
		tw = {t, 1'b0, inv, lk, f, 4'h0};
	endfunction

	task automatic complete_run();
		if (fail_count == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic ram_acc(input logic w, input logic [13:0] a, input logic [31:0] wd);
		@(posedge sys_clk);
		ram_req <= '{valid: 1'b1, write: w, addr: a, wdata: wd};
		@(posedge sys_clk);
		ram_req <= '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~wd};
		@(negedge sys_clk);
		chk({31'h0, ram_ack}, 32'h1);
		rd = ram_rdata;
	endtask

	task automatic lk(input logic w, input logic [20:0] t, input logic [8:0] i, input logic [3:0] ln,
		input logic [31:0] wd, input logic eh);
		logic h;
		logic m;
		u_ctl_core_model.look('{valid: 1'b1, write: w, waddr: {t, i}, lanes: ln, wdata: wd}, h, m, rd);
		chk({30'h0, h, m}, {30'h0, eh, ~eh});
	endtask

	task automatic fl(input logic [20:0] t, input logic [8:0] i, input logic [3:0] ln, input logic [31:0] d,
		input logic [1:0] e);
		logic dn;
		logic dr;
		u_ctl_core_model.put_fill('{valid: 1'b1, waddr: {t, i}, lanes: ln, data: d}, dn, dr);
		chk({30'h0, dn, dr}, {30'h0, e});
	endtask

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			complete_run();
		end
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		resetn = 1'b0;
		big_endian = 1'b0;
		set_cache_en = 4'hf;
		ram_req = '0;
		rd = '0;
		lt[0] = tw(21'h00111, 1'b0, 1'b1, 4'hf);
		lt[1] = tw(21'h00222, 1'b1, 1'b0, 4'hf);
		lt[2] = tw(21'h00333, 1'b1, 1'b0, 4'h0);
		lt[3] = tw(21'h00444, 1'b0, 1'b1, 4'h0);
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		// lines clear after reset
		ram_acc(1'b0, ra(2'd0, 9'h005, 1'b0), '0);
		chk(rd, 32'h0);
		lk(1'b0, 21'h1a2b3, 9'h005, 4'hf, '0, 1'b0);
		// partial fill, little endian
		fl(21'h1a2b3, 9'h005, 4'h3, 32'h11223344, 2'b10);
		ram_acc(1'b0, ra(2'd0, 9'h005, 1'b0), '0);
		chk(rd, tw(21'h1a2b3, 1'b0, 1'b0, 4'h3));
		lk(1'b0, 21'h1a2b3, 9'h005, 4'h3, '0, 1'b1);
		chk({16'h0, rd[15:0]}, 32'h3344);
		lk(1'b0, 21'h1a2b3, 9'h005, 4'hf, '0, 1'b0);
		lk(1'b0, 21'h1a2b2, 9'h005, 4'h3, '0, 1'b0);
		lk(1'b1, 21'h1a2b2, 9'h005, 4'hf, 32'h12345678, 1'b0);
		// write hit merges, then full word readable
		lk(1'b1, 21'h1a2b3, 9'h005, 4'hc, 32'haabb0000, 1'b1);
		lk(1'b0, 21'h1a2b3, 9'h005, 4'hf, '0, 1'b1);
		chk(rd, 32'haabb3344);
		ram_acc(1'b0, ra(2'd0, 9'h005, 1'b1), '0);
		chk(rd, 32'haabb3344);
		// big endian flag mapping, victim moves to way 1
		@(posedge sys_clk);
		big_endian <= 1'b1;
		fl(21'h0abcd, 9'h006, 4'h1, 32'h000000ee, 2'b10);
		ram_acc(1'b0, ra(2'd1, 9'h006, 1'b0), '0);
		chk(rd, tw(21'h0abcd, 1'b0, 1'b0, 4'h8));
		lk(1'b0, 21'h0abcd, 9'h006, 4'h1, '0, 1'b1);
		chk({24'h0, rd[7:0]}, 32'hee);
		lk(1'b0, 21'h0abcd, 9'h006, 4'h8, '0, 1'b0);
		@(posedge sys_clk);
		big_endian <= 1'b0;
		lk(1'b0, 21'h0abcd, 9'h006, 4'h1, '0, 1'b0);
		// fill with a matching tag merges into the present line
		fl(21'h0abcd, 9'h006, 4'h2, 32'h0000dd00, 2'b10);
		ram_acc(1'b0, ra(2'd1, 9'h006, 1'b1), '0);
		chk({16'h0, rd[15:0]}, 32'hddee);
		ram_acc(1'b0, ra(2'd1, 9'h006, 1'b0), '0);
		chk(rd, tw(21'h0abcd, 1'b0, 1'b0, 4'ha));
		// locked and invalidated entries at one index
		for (int w = 0; w < 4; w++) begin
			ram_acc(1'b1, ra(w[1:0], 9'h010, 1'b0), lt[w]);
		end
		ram_acc(1'b1, ra(2'd0, 9'h010, 1'b1), 32'hcafe0001);
		lk(1'b0, 21'h00111, 9'h010, 4'hf, '0, 1'b1);
		chk(rd, 32'hcafe0001);
		lk(1'b0, 21'h00222, 9'h010, 4'hf, '0, 1'b0);
		lk(1'b0, 21'h00444, 9'h010, 4'h1, '0, 1'b0);
		fl(21'h00555, 9'h010, 4'hf, 32'h1, 2'b01);
		ram_acc(1'b0, ra(2'd0, 9'h010, 1'b0), '0);
		chk(rd, lt[0]);
		// set 0 as plain ram, then no cache set at all
		@(posedge sys_clk);
		set_cache_en <= 4'he;
		ram_acc(1'b1, ra(2'd0, 9'h020, 1'b0), tw(21'h00777, 1'b0, 1'b0, 4'hf));
		ram_acc(1'b1, ra(2'd0, 9'h020, 1'b1), 32'h5a5a0ff0);
		lk(1'b0, 21'h00777, 9'h020, 4'hf, '0, 1'b0);
		@(posedge sys_clk);
		set_cache_en <= 4'h0;
		fl(21'h00888, 9'h020, 4'hf, 32'h2, 2'b01);
		ram_acc(1'b0, ra(2'd0, 9'h020, 1'b1), '0);
		chk(rd, 32'h5a5a0ff0);
		complete_run();
	end
endmodule // cache_tag_lookup_test
`default_nettype wire
